// [include/acr_params.svh]
// Operation
// - Channel bits 7..2; top codes pick fixed refs, DAC, sensor, ground
// - Codes 010000..010111 route port C pins 0..7; lower codes ports A, B
// - Codes 001000..001011 are reserved and connect no input
// - Writing one to go bit 1 starts a conversion; reads one while running
// - Hardware clears go when the conversion finishes
// - Enable bit 0 powers the converter; cleared means off, no conversion
// - Right justified: upper six bits of high result byte are zero
// - Left justified: lower six bits of low result byte are zero
// - Clock select: /2,/8,/32,/4,/16,/64; codes 011 and 111 RC clock
// - Two-bit reference select: 00 supply, 10 pin, 11 fixed, 01 reserved
// - Config bits 3..2 and trigger bits 7..5 ignore writes, read zero
// - Five-bit trigger source select; sources act on rising edge only
// - Left justified: high byte result 9..2, low byte 7..6 result 1..0
// - Right justified: high byte bits 1..0 hold result bits 9..8
// - Control registers reset to zero; result registers are not reset
// - Port A pins 4, 5 lose analog function with external clock
// - Right justified: low byte holds result bits 7..0
// - Selected trigger rising edge sets go; trigger code zero disables
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ACR_OFF_CTRL 12'h000
`define ACR_OFF_CFG 12'h004
`define ACR_OFF_TRIG 12'h008
`define ACR_OFF_RESH 12'h00C
`define ACR_OFF_RESL 12'h010
`define ACR_OFF_ISTAT 12'h014
`define ACR_OFF_IMASK 12'h018

// ****************************************
// Field positions and reset values
// ****************************************
`define ACR_CTL_EN 0
`define ACR_CTL_GO 1
`define ACR_CTL_CHAN_LSB 2
`define ACR_CFG_JUST 7
`define ACR_CFG_CS_LSB 4
`define ACR_CFG_REF_LSB 0
`define ACR_IRQ_DONE 0
`define ACR_IRQ_TRIG 1
`define ACR_CTRL_RST 8'h00
`define ACR_CFG_RST 8'h00
`define ACR_TRIG_RST 5'h00
`define ACR_IRQ_RST 2'h0

// ****************************************
// Channel, clock and trigger codes
// ****************************************
`define ACR_CHAN_GND 6'h3B
`define ACR_CHAN_TEMP 6'h3C
`define ACR_CHAN_DAC 6'h3D
`define ACR_CHAN_FIX1 6'h3E
`define ACR_CHAN_FIX2 6'h3F
`define ACR_CHAN_RSV_LO 6'h08
`define ACR_CHAN_RSV_HI 6'h0B
`define ACR_CHAN_PORT_PINS 24
`define ACR_CS_DIV2 3'h0
`define ACR_CS_DIV8 3'h1
`define ACR_CS_DIV32 3'h2
`define ACR_CS_RC_A 3'h3
`define ACR_CS_DIV4 3'h4
`define ACR_CS_DIV16 3'h5
`define ACR_CS_DIV64 3'h6
`define ACR_CS_RC_B 3'h7
`define ACR_DIV2_LAST 6'h01
`define ACR_DIV4_LAST 6'h03
`define ACR_DIV8_LAST 6'h07
`define ACR_DIV16_LAST 6'h0F
`define ACR_DIV32_LAST 6'h1F
`define ACR_DIV64_LAST 6'h3F
`define ACR_TRIG_OFF 5'h00
`define ACR_CONV_LAST 4'hA

`endif

// [include/acr_pkg.sv]
package acr_pkg;

   typedef enum logic [1:0] {
      ACR_IDLE = 2'b01,
      ACR_CONV = 2'b10
   } acr_phase_t;

   typedef struct packed {
      logic [5:0] cnt;
   } acr_div_state_t;

   typedef struct packed {
      acr_phase_t phase;
      logic [3:0] tick_cnt;
      logic [5:0] chan;
      logic en;
      logic just;
      logic [2:0] clk_sel;
      logic [1:0] ref_sel;
      logic [4:0] trig_sel;
      logic [31:0] trig_prev;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [31:0] prdata;
      logic pslverr;
   } acr_state_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } acr_result_t;

endpackage

// [rtl/_unused_guard.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [rtl/acr_clkdiv.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"

module acr_clkdiv (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [2:0] sel,
   input wire logic rc_tick,
   output logic tick
);

   acr_pkg::acr_div_state_t s;
   acr_pkg::acr_div_state_t next_s;
   logic [5:0] last;
   logic use_rc;

   // ****************************************
   // Divider terminal count
   // ****************************************
   always_comb begin
      use_rc = 1'b0;
      case (sel)
         `ACR_CS_DIV2: last = `ACR_DIV2_LAST;
         `ACR_CS_DIV4: last = `ACR_DIV4_LAST;
         `ACR_CS_DIV8: last = `ACR_DIV8_LAST;
         `ACR_CS_DIV16: last = `ACR_DIV16_LAST;
         `ACR_CS_DIV32: last = `ACR_DIV32_LAST;
         `ACR_CS_DIV64: last = `ACR_DIV64_LAST;
         default: begin
            last = `ACR_DIV2_LAST;
            use_rc = 1'b1;
         end
      endcase
   end

   // Counter restarts each conversion so the first period is whole
   always_comb begin
      next_s = s;
      if (!run || s.cnt == last) begin
         next_s.cnt = 6'h00;
      end else begin
         next_s.cnt = s.cnt + 6'h01;
      end
   end

   assign tick = run && (use_rc ? rc_tick : (s.cnt == last));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule
`default_nettype wire

// [rtl/acr_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"

module acr_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] trigger_in,
   input wire logic rc_clk_tick,
   input wire logic ext_clock_source,
   input wire logic [9:0] conv_data,
   output logic converter_enable,
   output logic conv_active,
   output logic conv_clock_tick,
   output logic [2:0] conversion_clock_select,
   output logic [1:0] positive_ref_select,
   output logic [7:0] mux_port_a,
   output logic [7:0] mux_port_b,
   output logic [7:0] mux_port_c,
   output logic [4:0] internal_source_sel,
   output logic irq
);

   acr_pkg::acr_state_t s;
   acr_pkg::acr_state_t next_s;
   acr_pkg::acr_result_t r;
   acr_pkg::acr_result_t next_r;

   logic setup;
   logic wr;
   logic addr_ok;
   logic [31:0] rd_mux;
   logic [31:0] rise;
   logic trig_hit;
   logic ctl_wr;
   logic go_start;
   logic en_next;
   logic finish;
   logic [1:0] irq_set;
   logic [1:0] irq_clr;
   logic [23:0] port_sel;

   // ****************************************
   // Conversion clock
   // ****************************************
   acr_clkdiv u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(s.phase == acr_pkg::ACR_CONV),
      .sel(s.clk_sel),
      .rc_tick(rc_clk_tick),
      .tick(conv_clock_tick)
   );

   // ****************************************
   // Bus decode and read mux
   // ****************************************
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign ctl_wr = wr && (paddr == `ACR_OFF_CTRL);

   always_comb begin
      addr_ok = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `ACR_OFF_CTRL: begin
            rd_mux[7:2] = s.chan;
            rd_mux[`ACR_CTL_GO] = (s.phase == acr_pkg::ACR_CONV);
            rd_mux[`ACR_CTL_EN] = s.en;
         end
         `ACR_OFF_CFG: begin
            rd_mux[`ACR_CFG_JUST] = s.just;
            rd_mux[6:4] = s.clk_sel;
            rd_mux[1:0] = s.ref_sel;
         end
         `ACR_OFF_TRIG: begin
            rd_mux[4:0] = s.trig_sel;
         end
         `ACR_OFF_RESH: begin
            rd_mux[7:0] = r.hi;
         end
         `ACR_OFF_RESL: begin
            rd_mux[7:0] = r.lo;
         end
         `ACR_OFF_ISTAT: begin
            rd_mux[1:0] = s.irq_stat;
         end
         `ACR_OFF_IMASK: begin
            rd_mux[1:0] = s.irq_mask;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   // ****************************************
   // Trigger edge detect
   // ****************************************
   // Each source keeps its own history so a select change cannot fake an edge
   assign rise = trigger_in & ~s.trig_prev;
   assign trig_hit = (s.trig_sel != `ACR_TRIG_OFF) &&
                     rise[s.trig_sel];

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_s = s;
      next_r = r;
      irq_set = 2'b00;
      irq_clr = 2'b00;
      finish = 1'b0;
      next_s.trig_prev = trigger_in;
      en_next = ctl_wr ? pwdata[`ACR_CTL_EN] : s.en;
      go_start = ctl_wr && pwdata[`ACR_CTL_GO];
      if (setup) begin
         next_s.prdata = rd_mux;
         next_s.pslverr = !addr_ok;
      end
      if (ctl_wr) begin
         next_s.chan = pwdata[7:2];
         next_s.en = pwdata[`ACR_CTL_EN];
      end
      if (wr && paddr == `ACR_OFF_CFG) begin
         next_s.just = pwdata[`ACR_CFG_JUST];
         next_s.clk_sel = pwdata[6:4];
         next_s.ref_sel = pwdata[1:0];
      end
      if (wr && paddr == `ACR_OFF_TRIG) begin
         next_s.trig_sel = pwdata[4:0];
      end
      if (wr && paddr == `ACR_OFF_RESH) begin
         next_r.hi = pwdata[7:0];
      end
      if (wr && paddr == `ACR_OFF_RESL) begin
         next_r.lo = pwdata[7:0];
      end
      if (wr && paddr == `ACR_OFF_ISTAT) begin
         irq_clr = pwdata[1:0];
      end
      if (wr && paddr == `ACR_OFF_IMASK) begin
         next_s.irq_mask = pwdata[1:0];
      end
      case (s.phase)
         acr_pkg::ACR_IDLE: begin
            next_s.tick_cnt = 4'h0;
            if (en_next && (go_start || trig_hit)) begin
               next_s.phase = acr_pkg::ACR_CONV;
               irq_set[`ACR_IRQ_TRIG] = trig_hit && !go_start;
            end
         end
         acr_pkg::ACR_CONV: begin
            if (!en_next || (ctl_wr && !pwdata[`ACR_CTL_GO])) begin
               next_s.phase = acr_pkg::ACR_IDLE;
            end else if (conv_clock_tick) begin
               if (s.tick_cnt == `ACR_CONV_LAST) begin
                  finish = 1'b1;
                  next_s.phase = acr_pkg::ACR_IDLE;
                  irq_set[`ACR_IRQ_DONE] = 1'b1;
               end else begin
                  next_s.tick_cnt = s.tick_cnt + 4'h1;
               end
            end
         end
         default: begin
            next_s.phase = acr_pkg::ACR_IDLE;
         end
      endcase
      // Completion outranks a software write to the result bytes
      if (finish) begin
         if (s.just) begin
            next_r.hi = {6'h00, conv_data[9:8]};
            next_r.lo = conv_data[7:0];
         end else begin
            next_r.hi = conv_data[9:2];
            next_r.lo = {conv_data[1:0], 6'h00};
         end
      end
      // Set wins over a clear in the same cycle
      next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
   end

   // ****************************************
   // State registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s.phase <= acr_pkg::ACR_IDLE;
         s.tick_cnt <= 4'h0;
         s.chan <= 6'(`ACR_CTRL_RST >> `ACR_CTL_CHAN_LSB);
         s.en <= 1'b0;
         s.just <= 1'b0;
         s.clk_sel <= 3'h0;
         s.ref_sel <= 2'h0;
         s.trig_sel <= `ACR_TRIG_RST;
         s.trig_prev <= 32'h0000_0000;
         s.irq_stat <= `ACR_IRQ_RST;
         s.irq_mask <= `ACR_IRQ_RST;
         s.prdata <= 32'h0000_0000;
         s.pslverr <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // Results survive resets; contents are unknown only after power-up
   always_ff @(posedge pclk) begin
      r <= next_r;
   end

   // ****************************************
   // Analog mux selects
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < `ACR_CHAN_PORT_PINS; gi++) begin : g_pin
         localparam logic [5:0] CODE = 6'(gi);
         logic blocked;
         assign blocked = ((CODE >= `ACR_CHAN_RSV_LO) &&
                           (CODE <= `ACR_CHAN_RSV_HI)) ||
                          (ext_clock_source &&
                           (gi == 4 || gi == 5));
         assign port_sel[gi] = s.en && !blocked &&
                               (s.chan == CODE);
      end
   endgenerate

   assign mux_port_a = port_sel[7:0];
   assign mux_port_b = port_sel[15:8];
   assign mux_port_c = port_sel[23:16];
   assign internal_source_sel[0] = s.en && s.chan == `ACR_CHAN_GND;
   assign internal_source_sel[1] = s.en && s.chan == `ACR_CHAN_TEMP;
   assign internal_source_sel[2] = s.en && s.chan == `ACR_CHAN_DAC;
   assign internal_source_sel[3] = s.en && s.chan == `ACR_CHAN_FIX1;
   assign internal_source_sel[4] = s.en && s.chan == `ACR_CHAN_FIX2;

   // ****************************************
   // Outputs
   // ****************************************
   assign prdata = s.prdata;
   assign pready = 1'b1;
   assign pslverr = s.pslverr;
   assign converter_enable = s.en;
   assign conv_active = (s.phase == acr_pkg::ACR_CONV);
   assign conversion_clock_select = s.clk_sel;
   assign positive_ref_select = s.ref_sel;
   assign irq = |(s.irq_stat & s.irq_mask);

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_go_starts_conv: assert property (
      s.phase == acr_pkg::ACR_IDLE && ctl_wr && pwdata[1] && pwdata[0]
      |=> conv_active)
      else $error("go write did not start conversion");

   a_finish_clears_go: assert property (
      finish |=> !conv_active)
      else $error("go not cleared at finish");

   // Held level must not restart; a write may still start one
   a_level_no_start: assert property (
      s.phase == acr_pkg::ACR_IDLE && !ctl_wr
      && (trigger_in & $past(trigger_in)) == trigger_in |=> !conv_active)
      else $error("held trigger level started conversion");

   a_disable_stops: assert property (
      !s.en |-> !conv_active)
      else $error("conversion running while disabled");

   a_right_hi_zero: assert property (
      finish && s.just |=> r.hi[7:2] == 6'h00)
      else $error("right justified high byte not zero filled");

   a_left_lo_zero: assert property (
      finish && !s.just |=> r.lo[5:0] == 6'h00)
      else $error("left justified low byte not zero filled");

   a_left_hi_bits: assert property (
      finish && !s.just |=> r.hi == $past(conv_data[9:2])
                            && r.lo[7:6] == $past(conv_data[1:0]))
      else $error("left justified result wrong");

   a_right_hi_bits: assert property (
      finish && s.just |=> r.hi[1:0] == $past(conv_data[9:8]))
      else $error("right justified high bits wrong");

   a_right_lo_bits: assert property (
      finish && s.just |=> r.lo == $past(conv_data[7:0]))
      else $error("right justified low byte wrong");

   a_trig_sets_go: assert property (
      s.phase == acr_pkg::ACR_IDLE && trig_hit && en_next |=> conv_active)
      else $error("trigger edge did not start conversion");

   a_reserved_none: assert property (
      s.chan >= 6'h08 && s.chan <= 6'h0B |-> mux_port_b[3:0] == 4'h0)
      else $error("reserved channel connected");

   a_ext_clk_pins: assert property (
      ext_clock_source |-> mux_port_a[5:4] == 2'b00)
      else $error("port A pin 4 or 5 routed with external clock");

   a_cfg_unused_zero: assert property (
      setup && paddr == `ACR_OFF_CFG |=> prdata[3:2] == 2'b00
                                        && prdata[31:8] == 24'h0)
      else $error("unused config bits read nonzero");

   c_right_finish: cover property (finish && s.just);
   c_left_finish: cover property (finish && !s.just);
   c_trig_start: cover property (s.phase == acr_pkg::ACR_IDLE && trig_hit
                                 && en_next);
   c_irq_raised: cover property ($rose(irq));
   c_abort: cover property (s.phase == acr_pkg::ACR_CONV && ctl_wr
                            && !pwdata[`ACR_CTL_GO]);

endmodule
`default_nettype wire

// [tb/acr_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"

module tb;
   // ****************************************
   // Bench signals
   // ****************************************
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, trigger_in, rd_data;
   logic rc_clk_tick, ext_clock_source, converter_enable, conv_active;
   logic conv_clock_tick, rd_err, j;
   logic [9:0] conv_data, d;
   logic [2:0] conversion_clock_select;
   logic [1:0] positive_ref_select, r;
   logic [7:0] mux_port_a, mux_port_b, mux_port_c, exp_hi, exp_lo;
   logic [4:0] internal_source_sel;
   logic [28:0] mux_all, exp_m;
   logic [15:0] exp_q[$];
   int bad_count, num_checks, cyc, tick_n, last_tick, tick_gap;
   int c, k, s, o, i;
   int gaps [8] = '{2, 8, 32, 3, 4, 16, 64, 3};

   acr_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
      .rc_clk_tick(rc_clk_tick), .ext_clock_source(ext_clock_source),
      .conv_data(conv_data), .converter_enable(converter_enable),
      .conv_active(conv_active), .conv_clock_tick(conv_clock_tick),
      .conversion_clock_select(conversion_clock_select),
      .positive_ref_select(positive_ref_select),
      .mux_port_a(mux_port_a), .mux_port_b(mux_port_b),
      .mux_port_c(mux_port_c), .internal_source_sel(internal_source_sel),
      .irq(irq)
   );

   assign mux_all = {internal_source_sel, mux_port_c, mux_port_b, mux_port_a};

   initial begin
      pclk = 0;
      forever #2.5 pclk = ~pclk;
   end

   // Period 3 so the RC tick gap is told apart from every divider
   always @(posedge pclk) begin
      rc_clk_tick <= (cyc % 3 == 0);
      if (conv_active === 1'b1 && conv_clock_tick === 1'b1) begin
         if (tick_n > 0) tick_gap = cyc - last_tick;
         last_tick = cyc;
         tick_n++;
      end
      cyc++;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task stop_test;
      $display("Checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge so the next call never re-drives in this step
      @(posedge pclk);
      if (n == 50) begin
         bad_count++;
         stop_test();
      end
   endtask

   task wr(input logic [11:0] a, input logic [7:0] wd);
      apb(1'b1, a, {24'h000000, wd});
   endtask

   task rd(input logic [11:0] a, input logic [7:0] e, input string n);
      apb(1'b0, a, 32'h00000000);
      chk(n, {24'h000000, e}, rd_data);
   endtask

   // Long enough for eleven ticks of the slowest divider
   task wait_idle;
      int n;
      for (n = 0; n < 2000 && conv_active !== 1'b0; n++) begin
         @(posedge pclk);
      end
      if (n == 2000) begin
         bad_count++;
         stop_test();
      end
   endtask

   task no_start(input int n, input string m);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge pclk);
         if (conv_active !== 1'b0) seen = 1'b1;
      end
      chk(m, 32'h0, {31'h0, seen});
   endtask

   // Bits 7:0 port A, 15:8 port B, 23:16 port C, 28:24 internal
   function logic [28:0] exp_mux(input int ch, input logic ext);
      logic [28:0] m;
      m = '0;
      if (ch < 24 && !(ch >= 8 && ch <= 11) && !(ext && (ch == 4 || ch == 5)))
         m[ch] = 1'b1;
      if (ch >= 59) m[ch - 35] = 1'b1;
      return m;
   endfunction

   initial begin
      {presetn, psel, penable, pwrite, ext_clock_source} = '0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      trigger_in = 32'h00000000;
      conv_data = 10'h000;
      {bad_count, num_checks, cyc, tick_n, last_tick, tick_gap} = '0;
      void'($urandom(32'h39C1));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`ACR_OFF_CTRL, 8'h00, "ctrl reset");
      rd(`ACR_OFF_CFG, 8'h00, "cfg reset");
      rd(`ACR_OFF_TRIG, 8'h00, "trig reset");
      chk("irq reset", 32'h0, {31'h0, irq});
      wr(`ACR_OFF_CFG, 8'hFF);
      rd(`ACR_OFF_CFG, 8'hF3, "cfg unused");
      wr(`ACR_OFF_TRIG, 8'hFF);
      rd(`ACR_OFF_TRIG, 8'h1F, "trig unused");
      wr(`ACR_OFF_TRIG, 8'h00);
      apb(1'b1, 12'h01C, 32'h000000FF);
      apb(1'b0, 12'h01C, 32'h00000000);
      chk("unmapped err", 32'h1, {31'h0, rd_err});
      chk("unmapped data", 32'h0, rd_data);
      $display("Test registers done");
      for (c = 0; c < 64; c++) begin
         ext_clock_source <= 1'($urandom);
         wr(`ACR_OFF_CTRL, {c[5:0], 2'b01});
         @(posedge pclk);
         exp_m = exp_mux(c, ext_clock_source);
         chk("mux", exp_m, mux_all);
      end
      wr(`ACR_OFF_CTRL, 8'h02);
      no_start(30, "go while off");
      chk("mux off", 32'h0, mux_all);
      chk("enable off", 32'h0, {31'h0, converter_enable});
      $display("Test channels done");
      wr(`ACR_OFF_IMASK, 8'h01);
      for (k = 0; k < 8; k++) begin
         j = 1'($urandom);
         r = 2'($urandom);
         d = 10'($urandom);
         conv_data <= d;
         wr(`ACR_OFF_CFG, {j, k[2:0], 2'b00, r});
         @(posedge pclk);
         chk("clk sel", k, {29'h0, conversion_clock_select});
         chk("ref sel", r, {30'h0, positive_ref_select});
         exp_q.push_back(j ? {6'h00, d} : {d, 6'h00});
         tick_n = 0;
         wr(`ACR_OFF_CTRL, 8'h03);
         rd(`ACR_OFF_CTRL, 8'h03, "go busy");
         chk("enable on", 32'h1, {31'h0, converter_enable});
         wait_idle();
         chk("ticks", 11, tick_n);
         chk("tick gap", gaps[k], tick_gap);
         {exp_hi, exp_lo} = exp_q.pop_front();
         rd(`ACR_OFF_CTRL, 8'h01, "go done");
         rd(`ACR_OFF_RESH, exp_hi, "res hi");
         rd(`ACR_OFF_RESL, exp_lo, "res lo");
         chk("irq done", 32'h1, {31'h0, irq});
         rd(`ACR_OFF_ISTAT, 8'h01, "status done");
         wr(`ACR_OFF_ISTAT, 8'h01);
         @(posedge pclk);
         chk("irq clear", 32'h0, {31'h0, irq});
      end
      $display("Test conversions done");
      wr(`ACR_OFF_IMASK, 8'h00);
      s = 1 + $urandom % 31;
      o = s % 31 + 1;
      wr(`ACR_OFF_TRIG, s[7:0]);
      trigger_in[o] <= 1'b1;
      no_start(10, "other trigger");
      trigger_in[s] <= 1'b1;
      for (i = 0; i < 5 && conv_active !== 1'b1; i++) begin
         @(posedge pclk);
      end
      chk("trigger start", 32'h1, {31'h0, conv_active});
      wait_idle();
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(`ACR_OFF_ISTAT, 8'h03, "status trig");
      wr(`ACR_OFF_IMASK, 8'h02);
      @(posedge pclk);
      chk("irq trig", 32'h1, {31'h0, irq});
      wr(`ACR_OFF_ISTAT, 8'h03);
      no_start(30, "level held");
      trigger_in <= 32'h00000000;
      no_start(10, "falling edge");
      wr(`ACR_OFF_TRIG, 8'h00);
      trigger_in <= 32'hFFFFFFFE;
      no_start(10, "trigger off");
      $display("Test trigger done");
      wr(`ACR_OFF_CTRL, 8'h03);
      repeat (3) @(posedge pclk);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("active reset", 32'h0, {31'h0, conv_active});
      rd(`ACR_OFF_CTRL, 8'h00, "ctrl rereset");
      rd(`ACR_OFF_CFG, 8'h00, "cfg rereset");
      rd(`ACR_OFF_RESH, exp_hi, "res hi kept");
      rd(`ACR_OFF_RESL, exp_lo, "res lo kept");
      $display("Test second reset done");
      stop_test();
   end

   initial begin
      repeat (90000) @(posedge pclk);
      bad_count++;
      stop_test();
   end
endmodule

`default_nettype wire
